/* File: srg_pkg.sv */
// Overview of operation
// - source-select 1 picks internal clock, 0 picks external rate-generator clock pin
// - internal source is the core clock divided by a fixed ratio
// - first stage counter reloads from divisor and makes the bit clock
// - bit clock frequency is input frequency over divisor plus one
// - divisor zero or odd gives exactly 50% duty
// - even divisor 2p gives p+1 input cycles high, p low
// - bit clock and frame pulse change only on selected input active edge, except bit clock at divisor zero and pulse clear on disable
// - edge-select 0 uses external rising edge, 1 uses falling edge
// - generator computes bit clock divide, frame period and frame width
// - frame resync works only with external input clock selected
// - resync disabled means bit clock runs free, never realigned
// - resync on: receive frame sync rise restarts divider and starts frame pulse
// - bit clock starts high after every resync
// - receive frame sync sampled on the edge that advances the bit clock
// - with resync on, frame period field is ignored
// - data clock mode bit 1 drives that data clock from bit clock
// - generator may stay in reset when all pins are driven externally
// - loopback routes transmit data, frame and clock onto receive paths
// - frame period stage is a 12-bit down counter of bit clocks
// - frame width stage is an 8-bit down counter of bit clocks
// - frame pulse low out of reset, runs only when both enables and the frame-generator select are 1
`default_nettype none
package srg_pkg;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h0C;
  localparam int DIV_W = 8;
  localparam int WID_W = 8;
  localparam int PER_W = 12;
  localparam int B_RG_RST = 0;
  localparam int B_FR_RST = 1;
  localparam int B_LOOP = 2;
  localparam int F_CSTP = 3;
  localparam int F_DIV = 0;
  localparam int F_WID = 8;
  localparam int F_PER = 16;
  localparam int B_SRC = 28;
  localparam int B_EDGE = 29;
  localparam int B_SYNC = 30;
  localparam int B_FRM_GEN = 31;
  localparam int B_RXCM = 0;
  localparam int B_TXCM = 1;
  localparam int B_TXFM = 2;
  localparam int B_RXFM = 3;
  localparam int S_CNT = 0;
  localparam int S_CLK = 8;
  localparam int S_FRM = 9;
  localparam int S_PER = 10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h1000_0001;
  localparam logic [31:0] PIN_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_001F;
  localparam logic [31:0] CFG_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] PIN_MASK = 32'h0000_000F;
  localparam int INT_RATIO_DEF = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FRM_OFF = 2'b00, FRM_HIGH = 2'b01, FRM_LOW = 2'b11} srg_frm_e;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } srg_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srg_axi_rsp_s;

  typedef struct packed {
    logic ext_rate_gen_clock_in;
    logic rx_frame_sync_pin;
    logic rx_clock_pin;
    logic tx_clock_pin;
    logic tx_frame_sync_pin;
    logic serial_data_in;
  } srg_pin_in_s;

  typedef struct packed {
    logic tx_clock_o;
    logic tx_clock_oe;
    logic rx_clock_o;
    logic rx_clock_oe;
    logic tx_frame_o;
    logic tx_frame_oe;
    logic rx_frame_o;
    logic rx_frame_oe;
    logic serial_data_out;
  } srg_pin_out_s;

  typedef struct packed {
    logic clk;
    logic frame;
    logic data;
  } srg_path_s;
endpackage
`default_nettype wire

/* File: srg_rate_gen.sv */
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module srg_rate_gen #(
  parameter int INT_RATIO = srg_pkg::INT_RATIO_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire srg_pkg::srg_axi_req_s axi_req,
  output var srg_pkg::srg_axi_rsp_s axi_rsp,
  input wire srg_pkg::srg_pin_in_s pin_in,
  input wire logic tx_data_int,
  output var srg_pkg::srg_pin_out_s pin_out,
  output var srg_pkg::srg_path_s rx_path,
  output var srg_pkg::srg_path_s tx_path,
  output logic gen_bit_clock,
  output logic gen_frame_pulse
);
  import srg_pkg::*;

  localparam int CW = $clog2(INT_RATIO + 1);
  localparam logic [CW-1:0] RATIO_LAST = CW'(INT_RATIO - 1);
  localparam logic [CW-1:0] RATIO_HALF = CW'(INT_RATIO / 2);

  logic [31:0] regs_r [3];
  srg_pin_in_s sync1_r;
  srg_pin_in_s sync2_r;
  logic ext_d_r;
  logic fsync_prev_r;
  logic [CW-1:0] int_cnt_r;
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic clk_r;
  logic pulse_r;
  srg_frm_e st_r;
  logic [PER_W-1:0] per_r;
  logic [WID_W-1:0] wid_r;

  logic rg_en, fr_en, loop_en, src_int, edge_fall, sync_en, frm_gen_sel;
  logic rxcm, txcm, txfm, rxfm;
  logic [DIV_W-1:0] div;
  logic [WID_W-1:0] wid_cfg;
  logic [PER_W-1:0] per_cfg;
  assign rg_en = regs_r[0][B_RG_RST];
  assign fr_en = regs_r[0][B_FR_RST];
  assign loop_en = regs_r[0][B_LOOP];
  assign div = regs_r[1][F_DIV +: DIV_W];
  assign wid_cfg = regs_r[1][F_WID +: WID_W];
  assign per_cfg = regs_r[1][F_PER +: PER_W];
  assign src_int = regs_r[1][B_SRC];
  assign edge_fall = regs_r[1][B_EDGE];
  assign sync_en = regs_r[1][B_SYNC];
  assign frm_gen_sel = regs_r[1][B_FRM_GEN];
  assign rxcm = regs_r[2][B_RXCM];
  assign txcm = regs_r[2][B_TXCM];
  assign txfm = regs_r[2][B_TXFM];
  assign rxfm = regs_r[2][B_RXFM];

  // every pin passes two flops before use
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      ext_d_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      ext_d_r <= sync2_r.ext_rate_gen_clock_in;
    end
  end

  // fixed-ratio internal source; rising edge where the count wraps
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      int_cnt_r <= '0;
    end else if (int_cnt_r == RATIO_LAST) begin
      int_cnt_r <= '0;
    end else begin
      int_cnt_r <= int_cnt_r + 1'b1;
    end
  end

  logic int_tick, ext_tick, tick, in_level;
  logic ext_now;
  assign ext_now = sync2_r.ext_rate_gen_clock_in;
  assign int_tick = (int_cnt_r == '0);
  assign ext_tick = edge_fall ? (ext_d_r & ~ext_now) : (~ext_d_r & ext_now);
  assign tick = src_int ? int_tick : ext_tick;
  assign in_level = src_int ? (int_cnt_r < RATIO_HALF) : (ext_now ^ edge_fall);

  // frame sync is looked at only on the advancing edge, so pulse length
  // does not matter
  logic resync_on, fsync_rise, resync_hit, bit_tick;
  assign resync_on = sync_en & ~src_int;
  assign fsync_rise = tick & sync2_r.rx_frame_sync_pin & ~fsync_prev_r;
  assign resync_hit = resync_on & fsync_rise & rg_en;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fsync_prev_r <= 1'b0;
    end else if (tick) begin
      fsync_prev_r <= sync2_r.rx_frame_sync_pin;
    end
  end

  assign cnt_nxt = (resync_hit || cnt_r == '0) ? div : cnt_r - 1'b1;
  assign bit_tick = rg_en & tick & (resync_hit | (cnt_r == '0));

  // divider; held reloaded and frozen while its enable is low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
    end else if (!rg_en) begin
      cnt_r <= div;
    end else begin
      if (tick) begin
        cnt_r <= cnt_nxt;
      end
      if (div == '0) begin
        clk_r <= in_level;
      end else if (tick) begin
        clk_r <= (cnt_nxt >= div - (div >> 1));
      end
    end
  end

  // frame stages; with resync the period counter is bypassed
  logic frm_en;
  logic frm_start;
  assign frm_en = fr_en & frm_gen_sel & rg_en;
  assign frm_start = resync_on ? resync_hit : (per_r == '0);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= FRM_OFF;
      pulse_r <= 1'b0;
      per_r <= '0;
      wid_r <= '0;
    end else if (!frm_en) begin
      st_r <= FRM_OFF;
      pulse_r <= 1'b0;
      per_r <= '0;
    end else if (bit_tick) begin
      if (frm_start) begin
        st_r <= FRM_HIGH;
        pulse_r <= 1'b1;
        per_r <= per_cfg;
        wid_r <= wid_cfg;
      end else begin
        if (!resync_on) begin
          per_r <= per_r - 1'b1;
        end
        unique case (st_r)
          FRM_HIGH: begin
            if (wid_r == '0) begin
              st_r <= FRM_LOW;
              pulse_r <= 1'b0;
            end else begin
              wid_r <= wid_r - 1'b1;
            end
          end
          FRM_OFF, FRM_LOW: begin
            st_r <= FRM_LOW;
          end
        endcase
      end
    end
  end

  assign gen_bit_clock = clk_r;
  assign gen_frame_pulse = pulse_r;

  // pin and internal path muxing, registered so every output is a flop
  logic txc_i, txf_i;
  assign txc_i = txcm ? clk_r : sync2_r.tx_clock_pin;
  assign txf_i = txfm ? pulse_r : sync2_r.tx_frame_sync_pin;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= '0;
      rx_path <= '0;
      tx_path <= '0;
    end else begin
      tx_path.clk <= txc_i;
      tx_path.frame <= txf_i;
      tx_path.data <= tx_data_int;
      rx_path.clk <= loop_en ? txc_i : (rxcm ? clk_r : sync2_r.rx_clock_pin);
      rx_path.frame <= loop_en ? txf_i : (rxfm ? pulse_r : sync2_r.rx_frame_sync_pin);
      rx_path.data <= loop_en ? tx_data_int : sync2_r.serial_data_in;
      pin_out.tx_clock_o <= clk_r;
      pin_out.tx_clock_oe <= txcm;
      pin_out.rx_clock_o <= loop_en ? txc_i : clk_r;
      pin_out.rx_clock_oe <= rxcm;
      pin_out.tx_frame_o <= pulse_r;
      pin_out.tx_frame_oe <= txfm;
      pin_out.rx_frame_o <= pulse_r;
      // an external frame sync must arrive on this pin under resync
      pin_out.rx_frame_oe <= rxfm & ~resync_on & ~loop_en;
      pin_out.serial_data_out <= tx_data_int;
    end
  end

  // register slave; write lands one cycle after both channels are held
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r, awready_r, wready_r, arready_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_fire, w_fire, ar_fire, do_write, wr_ok;
  logic aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;
  logic [1:0] widx;
  assign aw_fire = axi_req.awvalid & awready_r;
  assign w_fire = axi_req.wvalid & wready_r;
  assign ar_fire = axi_req.arvalid & arready_r;
  assign do_write = aw_got_r & w_got_r;
  assign widx = awaddr_r[3:2];
  assign wr_ok = (awaddr_r[ADDR_W-1] == 1'b0) && (widx != 2'h3);
  assign aw_got_nxt = (aw_got_r | aw_fire) & ~do_write;
  assign w_got_nxt = (w_got_r | w_fire) & ~do_write;
  assign bvalid_nxt = do_write | (bvalid_r & ~axi_req.bready);
  assign rvalid_nxt = ar_fire | (rvalid_r & ~axi_req.rready);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= ~aw_got_nxt & ~bvalid_nxt;
      wready_r <= ~w_got_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (aw_fire) begin
        awaddr_r <= axi_req.awaddr;
      end
      if (w_fire) begin
        wdata_r <= axi_req.wdata;
        wstrb_r <= axi_req.wstrb;
      end
      if (do_write) begin
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  localparam logic [31:0] RST_VAL [3] = '{CTRL_RST, CFG_RST, PIN_RST};
  localparam logic [31:0] WR_MASK [3] = '{CTRL_MASK, CFG_MASK, PIN_MASK};

  for (genvar g = 0; g < 3; g++) begin : g_reg
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        regs_r[g] <= RST_VAL[g];
      end else if (do_write && wr_ok && widx == 2'(g)) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_r[b]) begin
            regs_r[g][8*b +: 8] <= wdata_r[8*b +: 8] & WR_MASK[g][8*b +: 8];
          end
        end
      end
    end
  end

  logic [31:0] stat_word;
  always_comb begin
    stat_word = '0;
    stat_word[S_CNT +: DIV_W] = cnt_r;
    stat_word[S_CLK] = clk_r;
    stat_word[S_FRM] = pulse_r;
    stat_word[S_PER +: PER_W] = per_r;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_fire) begin
        rresp_r <= axi_req.araddr[ADDR_W-1] ? RESP_SLVERR : RESP_OKAY;
        if (axi_req.araddr[ADDR_W-1]) begin
          rdata_r <= '0;
        end else if (axi_req.araddr[3:2] == 2'h3) begin
          rdata_r <= stat_word;
        end else begin
          rdata_r <= regs_r[axi_req.araddr[3:2]];
        end
      end
    end
  end

  always_comb begin
    axi_rsp = '0;
    axi_rsp.awready = awready_r;
    axi_rsp.wready = wready_r;
    axi_rsp.bvalid = bvalid_r;
    axi_rsp.bresp = bresp_r;
    axi_rsp.arready = arready_r;
    axi_rsp.rvalid = rvalid_r;
    axi_rsp.rdata = rdata_r;
    axi_rsp.rresp = rresp_r;
  end

  default clocking dclk @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  reload_div_a: assert property (rg_en && tick && cnt_r == '0 |=> cnt_r == $past(div))
    else $error("divider did not reload");
  resync_high_a: assert property (resync_hit && div != '0 |=> clk_r)
    else $error("bit clock not high after resync");
  even_duty_a: assert property (rg_en && tick && div == 8'h02 && cnt_r == '0 ##1 rg_en
    && div == 8'h02 && !resync_on |-> clk_r && cnt_r == 8'h02)
    else $error("bit clock phase wrong for even divisor");
  // one settling edge: a pulse that was high when the hold began is cleared first
  held_reset_a: assert property (!rg_en ##1 !rg_en |=> $stable(clk_r) && $stable(pulse_r))
    else $error("outputs moved while generator held");
  frame_off_a: assert property (!frm_en |=> !pulse_r)
    else $error("frame pulse while frame logic disabled");
  no_resync_a: assert property (!resync_on && rg_en && tick && cnt_r != '0
    |=> cnt_r == $past(cnt_r) - 8'h01)
    else $error("resync without enable");
  ext_edge_a: assert property (!src_int && tick |-> (edge_fall ? $fell(ext_now) : $rose(ext_now)))
    else $error("advance on wrong external edge");
  loop_data_a: assert property (loop_en |=> rx_path.data == $past(tx_data_int))
    else $error("loopback data not routed");
  clk_dir_a: assert property (txcm && !loop_en ##1 txcm |-> pin_out.tx_clock_oe)
    else $error("transmit clock not driven");
  period_skip_a: assert property (resync_on && bit_tick && !resync_hit |=> $stable(per_r))
    else $error("period counter ran under resync");

  resync_c: cover property (resync_hit ##1 clk_r);
  frame_c: cover property (frm_en && !resync_on && $rose(pulse_r));
  loop_c: cover property (loop_en && txcm && $rose(rx_path.clk));
endmodule
`default_nettype wire

/* File: srg_rate_gen_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module srg_rate_gen_bench;
  import srg_pkg::*;
  localparam int RATIO = 2;
  localparam int EXT_PER = 6;
  localparam int FLEN = 8;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic tx_data_int = 1'b0;
  logic sdi = 1'b0;
  logic run = 1'b0;
  logic ext_clk, fs, gbc, gfp;
  logic [2:0] pg;
  // register model, updated from the rules on every accepted write
  logic [31:0] shadow [3] = '{CTRL_RST, CFG_RST, PIN_RST};
  srg_axi_req_s req = '0;
  srg_axi_rsp_s rsp;
  srg_pin_in_s pin_in;
  srg_pin_out_s pin_out;
  srg_path_s rx_path, tx_path;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int hi, per, dv, seed;
  logic [31:0] rd;

  // clock and frame pins unused here are held low
  assign pin_in = {ext_clk, fs, 3'b000, sdi};
  always #50 clk_sys = ~clk_sys;

  srg_serial_peer #(.HALF_NS(EXT_PER * 50), .FRAME_LEN(FLEN)) u_srg_serial_peer (.run(run),
    .ext_clk(ext_clk), .frame_sync(fs));
  srg_rate_gen #(.INT_RATIO(RATIO)) u_srg_rate_gen (.clk_sys(clk_sys), .arst_n(arst_n),
    .axi_req(req), .axi_rsp(rsp), .pin_in(pin_in), .tx_data_int(tx_data_int),
    .pin_out(pin_out), .rx_path(rx_path), .tx_path(tx_path), .gen_bit_clock(gbc),
    .gen_frame_pulse(gfp));

  always @(posedge clk_sys) begin
    tx_data_int <= 1'($urandom);
    sdi <= 1'($urandom);
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // each bus task starts on its own edge so no signal is driven twice at once
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge clk_sys);
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      b = rsp.bvalid;
      r = rsp.bresp;
      if (rsp.awready === 1'b1) aw = 1'b0;
      if (rsp.wready === 1'b1) w = 1'b0;
      @(posedge clk_sys);
      req.awvalid <= aw;
      req.wvalid <= w;
    end while (b !== 1'b1);
    req.bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
    if (er == RESP_OKAY) begin
      shadow[a[3:2]] = d & ((a[3:2] == 2'h0) ? CTRL_MASK :
        (a[3:2] == 2'h1) ? CFG_MASK : PIN_MASK);
    end
  endtask

  task automatic rdr(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ar, v;
    logic [1:0] r;
    @(posedge clk_sys);
    ar = 1'b1;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      v = rsp.rvalid;
      r = rsp.rresp;
      d = rsp.rdata;
      if (rsp.arready === 1'b1) ar = 1'b0;
      @(posedge clk_sys);
      req.arvalid <= ar;
    end while (v !== 1'b1);
    req.rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // every writable register against the model, in offset order
  task automatic readback;
    int unsigned q[$];
    for (int k = 0; k < 3; k++) q.push_back(shadow[k]);
    for (int k = 0; k < 3; k++) begin
      rdr(5'(4 * k), RESP_OKAY, rd);
      chk("readback", q.pop_front(), rd);
    end
  endtask

  // high time and period from one rise to the next, in system cycles
  task automatic meas(input bit f, output int h, output int p);
    logic o, c;
    o = 1'b1;
    h = 0;
    p = 0;
    repeat (4000) begin
      @(negedge clk_sys);
      c = f ? gfp : gbc;
      if (o === 1'b0 && c === 1'b1) break;
      o = c;
    end
    repeat (4000) begin
      p++;
      if (c === 1'b1) h++;
      @(negedge clk_sys);
      o = c;
      c = f ? gfp : gbc;
      if (o === 1'b0 && c === 1'b1) break;
    end
  endtask

  task automatic quiet(input logic m, output int n);
    n = 0;
    repeat (100) begin
      @(negedge clk_sys);
      if ({gbc & m, gfp} !== 2'b00) n++;
    end
  endtask

  function automatic int mhi(int d, int r);
    return (d == 0) ? r / 2 : (d / 2 + 1) * r;
  endfunction

  initial begin
    seed = $urandom(32'h4721);
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rdr(OFS_CTRL, RESP_OKAY, rd);
    chk("ctrl", CTRL_RST, rd);
    rdr(OFS_CFG, RESP_OKAY, rd);
    chk("cfg", CFG_RST, rd);
    rdr(OFS_PIN, RESP_OKAY, rd);
    chk("pin", PIN_RST, rd);
    rdr(5'h10, RESP_SLVERR, rd);
    chk("unmapped", 32'h0, rd);
    wr(OFS_STAT, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(5'h14, 32'h1, RESP_SLVERR);
    quiet(1'b1, hi);
    chk("held", 0, hi);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      dv = (i < 3) ? i : (i == 3) ? 255 : $urandom_range(40, 3);
      wr(OFS_CFG, {4'h1, 12'h0, 8'h0, 8'(dv)}, RESP_OKAY);
      meas(1'b0, hi, per);
      meas(1'b0, hi, per);
      chk("clk_hi", mhi(dv, RATIO), hi);
      chk("clk_per", (dv + 1) * RATIO, per);
    end
    // frame enable and frame-generator select must both be up before any frame appears
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, i ? 32'h1 : 32'h3, RESP_OKAY);
      wr(OFS_CFG, {i ? 4'h9 : 4'h1, 12'd9, 8'd2, 8'd1}, RESP_OKAY);
      quiet(1'b0, hi);
      chk("frame_off", 0, hi);
    end
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    meas(1'b1, hi, per);
    meas(1'b1, hi, per);
    chk("frm_hi", 3 * 2 * RATIO, hi);
    chk("frm_per", 10 * 2 * RATIO, per);
    wr(OFS_PIN, 32'h7, RESP_OKAY);
    wr(OFS_CTRL, 32'h7, RESP_OKAY);
    // sample off the edge so the reference is not raced by the flop update
    @(negedge clk_sys);
    pg = {gbc, gfp, tx_data_int};
    repeat (40) begin
      @(negedge clk_sys);
      chk("loop", 32'(tx_path), 32'(rx_path));
      chk("txclk", {31'h0, pg[2]}, {31'h0, pin_out.tx_clock_o});
      chk("rxclk", {31'h0, pg[2]}, {31'h0, pin_out.rx_clock_o});
      chk("txfrm", {31'h0, pg[1]}, {31'h0, pin_out.tx_frame_o});
      chk("dout", {31'h0, pg[0]}, {31'h0, pin_out.serial_data_out});
      chk("oe", 32'hE, {28'h0, pin_out.tx_clock_oe, pin_out.rx_clock_oe,
        pin_out.tx_frame_oe, pin_out.rx_frame_oe});
      pg = {gbc, gfp, tx_data_int};
    end
    @(posedge clk_sys);
    run <= 1'b1;
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    wr(OFS_PIN, 32'h0, RESP_OKAY);
    // free running: arriving frame syncs must not bend the period
    for (int e = 0; e < 2; e++) begin
      wr(OFS_CFG, {2'b00, 1'(e), 1'b0, 12'd0, 8'd0, 8'd1}, RESP_OKAY);
      meas(1'b0, hi, per);
      meas(1'b0, hi, per);
      chk("ext_hi", EXT_PER, hi);
      chk("ext_per", 2 * EXT_PER, per);
    end
    wr(OFS_PIN, 32'h6, RESP_OKAY);
    wr(OFS_CFG, {4'hC, 12'd100, 8'd0, 8'd3}, RESP_OKAY);
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    meas(1'b1, hi, per);
    meas(1'b1, hi, per);
    chk("resync_clk", 1, {31'h0, gbc});
    chk("resync_per", FLEN * EXT_PER, per);
    chk("resync_hi", 4 * EXT_PER, hi);
    readback();
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: srg_serial_peer.sv */
`timescale 1ns/100ps
`default_nettype none
module srg_serial_peer #(
  parameter int HALF_NS = 300,
  parameter int FRAME_LEN = 8
) (
  input wire logic run,
  output logic ext_clk,
  output logic frame_sync
);
  int n;
  // sync moves on the falling edge so a rising-edge sampler sees a clean level
  initial begin
    ext_clk = 1'b0;
    frame_sync = 1'b0;
    n = 0;
    #37;
    forever begin
      #HALF_NS;
      if (run === 1'b1) begin
        ext_clk = ~ext_clk;
        if (ext_clk == 1'b0) begin
          n = (n + 1) % FRAME_LEN;
          frame_sync = (n == 0);
        end
      end
    end
  end
endmodule
`default_nettype wire
